// ---- bench/sdram_card_model.sv ----
// partner model: sdram mode latch and card cycle phase meter
`timescale 1ns/1ns
`default_nettype none
module sdram_card_model (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        mrs_n,
    input  wire logic        cs2_n,
    input  wire logic        cs3_n,
    input  wire logic [11:0] addr,
    input  wire logic        addr_valid,
    input  wire logic        strobe_n,
    output var  logic [11:0] mode2,
    output var  logic [11:0] mode3,
    output var  logic [3:0]  setup_cnt,
    output var  logic [3:0]  hold_cnt,
    output var  logic [3:0]  mrs_cnt
);
    logic prev_valid;   // address valid one cycle earlier
    logic after_strobe; // strobe already seen in this card cycle
    // memory takes its mode from the address lines, never from data
    always_ff @(posedge clk) begin
        if (srst) begin
            mode2 <= 12'h000;
            mode3 <= 12'h000;
            mrs_cnt <= 4'h0;
        end else if (!mrs_n) begin
            mrs_cnt <= mrs_cnt + 4'h1;
            if (!cs2_n) mode2 <= addr;
            if (!cs3_n) mode3 <= addr;
        end
    end
    // counts stay after the cycle ends so the bench can read them late
    always_ff @(posedge clk) begin
        prev_valid <= addr_valid;
        if (addr_valid && !prev_valid) begin
            setup_cnt <= 4'h1;
            hold_cnt <= 4'h0;
            after_strobe <= 1'b0;
        end else if (addr_valid && !strobe_n) after_strobe <= 1'b1;
        else if (addr_valid && after_strobe) hold_cnt <= hold_cnt + 4'h1;
        else if (addr_valid) setup_cnt <= setup_cnt + 4'h1;
    end
endmodule : sdram_card_model
`default_nettype wire

// ---- bench/strobe_mode_ctrl_assertions.sv ----
// checker: port-level assertions for the card strobe and sdram mode block
`timescale 1ns/1ns
`default_nettype none
module strobe_mode_ctrl_assertions
    import strobe_mode_pkg::*;
(
    input wire logic        CLK_SYS,
    input wire logic        SRST,
    input wire logic [31:0] AVS_ADDRESS,
    input wire logic        AVS_READ,
    input wire logic        AVS_WRITE,
    input wire logic        AVS_WAITREQUEST,
    input wire logic        CARD_ADDR_VALID,
    input wire logic        CARD_STROBE_N,
    input wire logic        MEM_CS2_N,
    input wire logic        MEM_CS3_N,
    input wire logic        MEM_MRS_N,
    input wire logic [11:0] MEM_ADDR
);
    // one clock domain, so clock and reset are given once
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SRST);
    AST_ACK_ONE: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
        else $error("bus answer held longer than one cycle");
    AST_ACK_BOUND: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
        |-> ##[0:4] !AVS_WAITREQUEST)
        else $error("bus request left unanswered");
    AST_ACK_CAUSE: assert property (!AVS_WAITREQUEST |-> AVS_READ || AVS_WRITE)
        else $error("bus answer without a request");
    AST_MRS_ONE: assert property (!MEM_MRS_N |=> MEM_MRS_N)
        else $error("mode command longer than one cycle");
    AST_MRS_CS: assert property (!MEM_MRS_N |-> MEM_CS2_N != MEM_CS3_N)
        else $error("mode command not on exactly one area");
    AST_CS_MRS: assert property (!MEM_CS2_N || !MEM_CS3_N |-> !MEM_MRS_N)
        else $error("area select without mode command");
    AST_MRS_WINDOW: assert property ($fell(MEM_MRS_N) |-> AVS_WRITE
        && ((AVS_ADDRESS & MODE_WIN_SPAN_MASK)
            == (MEM_CS2_N ? MODE_WIN_AREA3_BASE : MODE_WIN_AREA2_BASE)))
        else $error("mode command not caused by a window write");
    AST_ADDR_HELD: assert property (MEM_MRS_N && $past(MEM_MRS_N) |-> $stable(MEM_ADDR))
        else $error("memory address moved outside a mode command");
    AST_STROBE_ONE: assert property ($fell(CARD_STROBE_N) |=> $rose(CARD_STROBE_N))
        else $error("strobe width not one cycle");
    AST_STROBE_FRAME: assert property (!CARD_STROBE_N
        |-> CARD_ADDR_VALID && $past(CARD_ADDR_VALID) ##1 CARD_ADDR_VALID)
        else $error("strobe outside address setup and hold");
endmodule : strobe_mode_ctrl_assertions
`default_nettype wire

// ---- bench/strobe_mode_ctrl_tb.sv ----
// testbench: register, card cycle and mode-set scenarios
`timescale 1ns/1ns
`default_nettype none
module strobe_mode_ctrl_tb
    import strobe_mode_pkg::*;
;
    logic        clk_sys = 1'b0, srst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic [31:0] avs_address = 32'h0, avs_writedata = 32'h0, avs_readdata, rd;
    logic [3:0]  avs_byteenable = 4'h0, setup_cnt, hold_cnt, mrs_cnt;
    logic        card_req = 1'b0, card_area6 = 1'b0, card_addr_valid, card_strobe_n;
    logic        card_done, mem_cs2_n, mem_cs3_n, mem_mrs_n, avs_waitrequest;
    logic [11:0] mem_addr, mode2, mode3;
    logic [15:0] t;
    int          err_total = 0, cmp_count = 0;
    // mode table: bus config, offset, value the memory must see
    // bit 11 enabled where the expected value needs it; one entry masks both upper bits
    logic [2:0]  cfg_t [6] = '{3'h5, 3'h5, 3'h4, 3'h7, 3'h1, 3'h6};
    logic [11:0] off_t [6] = '{12'h8c0, 12'h8c0, 12'h8c0, 12'hffc, 12'hffc, 12'hffc};
    logic [11:0] exp_t [6] = '{12'h230, 12'h230, 12'h460, 12'h3ff, 12'h0ff, 12'h7fe};
    always #10 clk_sys = ~clk_sys;
    strobe_mode_ctrl DUT (.CLK_SYS(clk_sys), .SRST(srst), .AVS_ADDRESS(avs_address),
        .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
        .AVS_BYTEENABLE(avs_byteenable), .AVS_READDATA(avs_readdata),
        .AVS_WAITREQUEST(avs_waitrequest), .CARD_REQ(card_req), .CARD_AREA6(card_area6),
        .CARD_ADDR_VALID(card_addr_valid), .CARD_STROBE_N(card_strobe_n), .CARD_DONE(card_done),
        .MEM_CS2_N(mem_cs2_n), .MEM_CS3_N(mem_cs3_n), .MEM_MRS_N(mem_mrs_n), .MEM_ADDR(mem_addr));
    sdram_card_model MODEL (.clk(clk_sys), .srst(srst), .mrs_n(mem_mrs_n), .cs2_n(mem_cs2_n),
        .cs3_n(mem_cs3_n), .addr(mem_addr), .addr_valid(card_addr_valid),
        .strobe_n(card_strobe_n), .mode2(mode2), .mode3(mode3), .setup_cnt(setup_cnt),
        .hold_cnt(hold_cnt), .mrs_cnt(mrs_cnt));
    // verdict and end of run, also reached when a wait runs out
    task end_sim;
        if (err_total == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim
    // value compare, four-state exact
    task cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : cmp
    // avalon transfer: hold everything until waitrequest is sampled low
    task av(input logic wr, input logic [31:0] addr, input logic [31:0] data,
            input logic [3:0] be);
        int n;
        @(posedge clk_sys);
        avs_address <= addr;
        avs_writedata <= data;
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= !wr;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_sys);
            if (avs_waitrequest === 1'b0) break;
        end
        if (n == 20) begin
            err_total++;
            end_sim();
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : av
    // one card cycle; request dropped once address is out, so no retrigger
    task card(input logic a6, input logic [3:0] es, input logic [3:0] eh);
        int n;
        int m;
        @(posedge clk_sys);
        card_area6 <= a6;
        card_req <= 1'b1;
        for (n = 0; n < 50 && card_addr_valid !== 1'b1; n++) @(posedge clk_sys);
        card_req <= 1'b0;
        for (m = 0; m < 50 && card_done !== 1'b1; m++) @(posedge clk_sys);
        if (n == 50 || m == 50) begin
            err_total++;
            end_sim();
        end
        repeat (2) @(posedge clk_sys);
        cmp("setup cycles", {28'h0, es}, {28'h0, setup_cnt});
        cmp("hold cycles", {28'h0, eh}, {28'h0, hold_cnt});
    endtask : card
    // scatter a 3-bit code over its three field positions
    function automatic logic [15:0] fld(input logic [2:0] c, input int hi, input int m,
                                        input int l);
        fld = 16'h0;
        fld[hi] = c[2];
        fld[m] = c[1];
        fld[l] = c[0];
    endfunction : fld
    initial begin
        repeat (20) @(posedge clk_sys);
        srst <= 1'b0;
        av(1'b0, STROBE_TIMING_ADDR, 32'h0, 4'h3);
        cmp("timing reset", 32'h0, rd);
        av(1'b1, STROBE_TIMING_ADDR, 32'hffff, 4'h3);
        av(1'b0, STROBE_TIMING_ADDR, 32'h0, 4'h3);
        cmp("timing readback", 32'hcfff, rd);
        av(1'b0, 32'hffffc0f0, 32'h0, 4'hf);
        cmp("unmapped read", 32'h0, rd);
        av(1'b0, MODE_WIN_AREA2_BASE + 32'h8c0, 32'h0, 4'hf);
        cmp("window read", 32'h0, rd);
        // opposite codes in neighbouring fields expose swapped bit positions
        for (int c = 0; c < 8; c++) begin
            t = fld(3'(c), A5_ASSERT_HI, A5_ASSERT_M, A5_ASSERT_L)
              | fld(3'(7 - c), A5_HOLD_HI, A5_HOLD_M, A5_HOLD_L)
              | fld(3'(7 - c), A6_ASSERT_HI, A6_ASSERT_M, A6_ASSERT_L)
              | fld(3'(c), A6_HOLD_HI, A6_HOLD_M, A6_HOLD_L);
            av(1'b1, STROBE_TIMING_ADDR, {16'h0, t}, 4'h3);
            card(1'b0, 4'(c + 1), 4'(8 - c));
            card(1'b1, 4'(8 - c), 4'(c + 1));
        end
        // mode is set before any memory access; offsets stay inside the window
        for (int k = 0; k < 6; k++) begin
            av(1'b1, BUS_CFG_ADDR, {29'h0, cfg_t[k]}, 4'h1);
            av(1'b1, (k[0] ? MODE_WIN_AREA3_BASE : MODE_WIN_AREA2_BASE) + {20'h0, off_t[k]},
               32'hdeadbeef ^ 32'(k), 4'hf);
            repeat (3) @(posedge clk_sys);
            cmp("mode value", {20'h0, exp_t[k]}, {20'h0, k[0] ? mode3 : mode2});
        end
        cmp("mode commands", 32'h6, {28'h0, mrs_cnt});
        av(1'b0, STATUS_ADDR, 32'h0, 4'hf);
        cmp("status idle", 32'h0, rd);
        av(1'b0, BUS_CFG_ADDR, 32'h0, 4'hf);
        cmp("bus cfg readback", 32'h6, rd);
        end_sim();
    end
endmodule : strobe_mode_ctrl_tb
bind strobe_mode_ctrl strobe_mode_ctrl_assertions CHK (.CLK_SYS(CLK_SYS), .SRST(SRST),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .CARD_ADDR_VALID(CARD_ADDR_VALID),
    .CARD_STROBE_N(CARD_STROBE_N), .MEM_CS2_N(MEM_CS2_N), .MEM_CS3_N(MEM_CS3_N),
    .MEM_MRS_N(MEM_MRS_N), .MEM_ADDR(MEM_ADDR));
`default_nettype wire

// ---- hdl/half_cycle_timer.sv ----
// half-cycle phase counter: runs a programmed number of half cycles
`timescale 1ns/1ns
`default_nettype none
module half_cycle_timer
    import strobe_mode_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       start,
    input  wire logic [3:0] halves,
    output var  logic       done
);
    logic [3:0] count_reg; // remaining half cycles
    logic       busy_reg;  // counting

    // each clock edge advances two half cycles; a restart on the last edge wins
    always_ff @(posedge clk) begin
        if (srst) begin
            count_reg <= 4'h0;
            busy_reg  <= 1'b0;
        end else if (start) begin
            count_reg <= halves;
            busy_reg  <= 1'b1;
        end else if (busy_reg) begin
            if (count_reg <= 4'h2) begin
                busy_reg <= 1'b0; // last edge of the phase
            end else begin
                count_reg <= count_reg - 4'h2;
            end
        end
    end

    // done is decoded, not registered: a registered flag would add a cycle to every phase
    always_comb begin
        done = busy_reg && (count_reg <= 4'h2);
    end
endmodule : half_cycle_timer
`default_nettype wire

// ---- hdl/strobe_mode_ctrl.sv ----
// card strobe timing register, card cycle sequencer and sdram mode-set path
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
module strobe_mode_ctrl
    import strobe_mode_pkg::*;
(
    input  wire logic        CLK_SYS,
    input  wire logic        SRST,
    input  wire logic [31:0] AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output var  logic [31:0] AVS_READDATA,
    output var  logic        AVS_WAITREQUEST,
    input  wire logic        CARD_REQ,
    input  wire logic        CARD_AREA6,
    output var  logic        CARD_ADDR_VALID,
    output var  logic        CARD_STROBE_N,
    output var  logic        CARD_DONE,
    output var  logic        MEM_CS2_N,
    output var  logic        MEM_CS3_N,
    output var  logic        MEM_MRS_N,
    output var  logic [11:0] MEM_ADDR
);
    logic [15:0] strobe_timing_reg; // card_strobe_timing contents
    logic [2:0]  bus_cfg_reg;       // bus width and writable mode bits
    logic        mrs_busy_reg;      // mode command in flight
    logic [1:0]  mrs_cnt_reg;       // command phase counter
    logic        mrs_area3_reg;     // target area of command
    logic [11:0] mrs_addr_next;     // address lines for command
    logic        ack_reg;           // one-cycle answer slot
    logic [3:0]  card_halves_next;  // half-cycle count for the next phase
    logic        timer_start;       // load phase timer
    logic        timer_done;        // phase spent
    logic        card_req_s1;       // request synchroniser, first stage
    logic        card_req_s2;       // request synchroniser, second stage
    logic        area6_s1;          // area select synchroniser, first stage
    logic        area6_s2;          // area select synchroniser, second stage
    logic        area6_reg;         // area latched for the cycle
    card_state_t card_state_reg;    // card cycle state

    // window decode used by several processes
    function automatic logic hits_window(input logic [31:0] addr, input logic [31:0] base);
        hits_window = (addr & MODE_WIN_SPAN_MASK) == base;
    endfunction : hits_window

    // assemble a 3-bit delay code from three scattered bits
    function automatic logic [2:0] field3(input logic [15:0] r, input int hi, input int m,
                                          input int l);
        field3 = {r[hi], r[m], r[l]};
    endfunction : field3

    // code n maps to 2n+1 half cycles, i.e. n+0.5 bus cycles
    function automatic logic [3:0] code_halves(input logic [2:0] code);
        code_halves = {code, 1'b0} + HALF_BASE;
    endfunction : code_halves

    wire logic req_valid = (AVS_READ | AVS_WRITE) & ~ack_reg;
    wire logic hit_a2    = hits_window(AVS_ADDRESS, MODE_WIN_AREA2_BASE);
    wire logic hit_a3    = hits_window(AVS_ADDRESS, MODE_WIN_AREA3_BASE);
    wire logic mode_wr   = AVS_WRITE & (hit_a2 | hit_a3);
    // a mode write stalls while a previous command is still on the pins
    wire logic stall     = mode_wr & mrs_busy_reg;

    // waitrequest drops for exactly one cycle per taken access
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req_valid & ~stall;
        end
    end

    // waitrequest is high except during the answer cycle
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            AVS_WAITREQUEST <= 1'b1;
        end else begin
            AVS_WAITREQUEST <= ~(req_valid & ~stall);
        end
    end

    // timing register: power-on value held until software writes it
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            strobe_timing_reg <= STROBE_TIMING_RESET;
        end else if (AVS_WRITE && req_valid && AVS_ADDRESS == STROBE_TIMING_ADDR) begin
            if (AVS_BYTEENABLE[0]) begin
                strobe_timing_reg[7:0] <= AVS_WRITEDATA[7:0] & STROBE_TIMING_WMASK[7:0];
            end
            if (AVS_BYTEENABLE[1]) begin
                strobe_timing_reg[15:8] <= AVS_WRITEDATA[15:8] & STROBE_TIMING_WMASK[15:8];
            end
        end
    end

    // bus configuration: width and which upper mode bits the memory type accepts
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            bus_cfg_reg <= BUS_CFG_RESET;
        end else if (AVS_WRITE && req_valid && AVS_ADDRESS == BUS_CFG_ADDR
                     && AVS_BYTEENABLE[0]) begin
            bus_cfg_reg <= AVS_WRITEDATA[2:0];
        end
    end

    // read mux; windows are write-only and read zero, as does any unmapped address
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            AVS_READDATA <= 32'h0;
        end else if (AVS_READ && req_valid) begin
            unique case (AVS_ADDRESS)
                STROBE_TIMING_ADDR: AVS_READDATA <= {16'h0, strobe_timing_reg};
                BUS_CFG_ADDR:       AVS_READDATA <= {29'h0, bus_cfg_reg};
                STATUS_ADDR:        AVS_READDATA <= {30'h0, card_state_reg != CARD_IDLE,
                                                     mrs_busy_reg};
                default:            AVS_READDATA <= 32'h0;
            endcase
        end
    end

    // mode value from offset only; upper bits masked per memory type, low two dropped
    always_comb begin
        mrs_addr_next = 12'h0;
        if (bus_cfg_reg[CFG_BUS32]) begin
            mrs_addr_next[9:0] = {2'b00, AVS_ADDRESS[9:2]};
            mrs_addr_next[8]   = AVS_ADDRESS[10] & bus_cfg_reg[CFG_BIT10_EN];
            mrs_addr_next[9]   = AVS_ADDRESS[11] & bus_cfg_reg[CFG_BIT11_EN];
        end else begin
            mrs_addr_next[10:0] = {2'b00, AVS_ADDRESS[9:2], 1'b0};
            mrs_addr_next[0]    = 1'b0;
            mrs_addr_next[9]    = AVS_ADDRESS[10] & bus_cfg_reg[CFG_BIT10_EN];
            mrs_addr_next[10]   = AVS_ADDRESS[11] & bus_cfg_reg[CFG_BIT11_EN];
        end
    end

    // one mode command per accepted window write; write data never looked at
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            mrs_busy_reg  <= 1'b0;
            mrs_cnt_reg   <= 2'h0;
            mrs_area3_reg <= 1'b0;
            MEM_ADDR      <= 12'h0;
        end else if (mode_wr && req_valid && !mrs_busy_reg) begin
            mrs_busy_reg  <= 1'b1;
            mrs_cnt_reg   <= 2'h0;
            mrs_area3_reg <= hit_a3;
            MEM_ADDR      <= mrs_addr_next;
        end else if (mrs_busy_reg) begin
            if (mrs_cnt_reg == MRS_LAST) begin
                mrs_busy_reg <= 1'b0;
            end else begin
                mrs_cnt_reg <= mrs_cnt_reg + 2'h1;
            end
        end
    end

    // command pins: chip select of the addressed area plus the command strobe
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            MEM_CS2_N <= 1'b1;
            MEM_CS3_N <= 1'b1;
            MEM_MRS_N <= 1'b1;
        end else begin
            MEM_MRS_N <= ~(mode_wr && req_valid && !mrs_busy_reg);
            MEM_CS2_N <= ~(mode_wr && req_valid && !mrs_busy_reg && hit_a2);
            MEM_CS3_N <= ~(mode_wr && req_valid && !mrs_busy_reg && hit_a3);
        end
    end

    // card request and area come from outside the clock domain
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            card_req_s1 <= 1'b0;
            card_req_s2 <= 1'b0;
            area6_s1    <= 1'b0;
            area6_s2    <= 1'b0;
        end else begin
            card_req_s1 <= CARD_REQ;
            card_req_s2 <= card_req_s1;
            area6_s1    <= CARD_AREA6;
            area6_s2    <= area6_s1;
        end
    end

    // phase length: setup and hold from timing fields, strobe width fixed here
    always_comb begin
        card_halves_next = STROBE_HALVES;
        timer_start      = 1'b0;
        unique case (card_state_reg)
            CARD_IDLE: begin
                timer_start = card_req_s2;
                card_halves_next = area6_s2
                    ? code_halves(field3(strobe_timing_reg, A6_ASSERT_HI, A6_ASSERT_M,
                                         A6_ASSERT_L))
                    : code_halves(field3(strobe_timing_reg, A5_ASSERT_HI, A5_ASSERT_M,
                                         A5_ASSERT_L));
            end
            CARD_SETUP: begin
                timer_start = timer_done;
            end
            CARD_STROBE: begin
                timer_start = timer_done;
                card_halves_next = area6_reg
                    ? code_halves(field3(strobe_timing_reg, A6_HOLD_HI, A6_HOLD_M,
                                         A6_HOLD_L))
                    : code_halves(field3(strobe_timing_reg, A5_HOLD_HI, A5_HOLD_M,
                                         A5_HOLD_L));
            end
            CARD_HOLD: begin
                timer_start = 1'b0;
            end
        endcase
    end

    half_cycle_timer u_timer (
        .clk    (CLK_SYS),
        .srst   (SRST),
        .start  (timer_start),
        .halves (card_halves_next),
        .done   (timer_done)
    );

    // card cycle: address out, delayed strobe, strobe, address hold
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            card_state_reg  <= CARD_IDLE;
            area6_reg       <= 1'b0;
            CARD_ADDR_VALID <= 1'b0;
            CARD_STROBE_N   <= 1'b1;
            CARD_DONE       <= 1'b0;
        end else begin
            CARD_DONE <= 1'b0;
            unique case (card_state_reg)
                CARD_IDLE: if (card_req_s2) begin
                    card_state_reg  <= CARD_SETUP;
                    area6_reg       <= area6_s2;
                    CARD_ADDR_VALID <= 1'b1;
                end
                CARD_SETUP: if (timer_done) begin
                    card_state_reg <= CARD_STROBE;
                    CARD_STROBE_N  <= 1'b0;
                end
                CARD_STROBE: if (timer_done) begin
                    card_state_reg <= CARD_HOLD;
                    CARD_STROBE_N  <= 1'b1;
                end
                CARD_HOLD: if (timer_done) begin
                    card_state_reg  <= CARD_IDLE;
                    CARD_ADDR_VALID <= 1'b0;
                    CARD_DONE       <= 1'b1;
                end
            endcase
        end
    end
endmodule : strobe_mode_ctrl
`default_nettype wire

// ---- pkg/strobe_mode_pkg.sv ----
// package: register map, field positions and timing constants for the card strobe and sdram mode block
package strobe_mode_pkg;
    // avalon word addresses are byte addresses here (offsets are multiples of four)
    localparam logic [31:0] MODE_WIN_AREA2_BASE   = 32'hffffd000; // sdram_mode_window_area2
    localparam logic [31:0] MODE_WIN_AREA3_BASE   = 32'hffffe000; // sdram_mode_window_area3
    localparam logic [31:0] MODE_WIN_SPAN_MASK    = 32'hfffff000; // window covers 4 KiB
    localparam logic [31:0] STROBE_TIMING_ADDR    = 32'hffffc000; // card_strobe_timing
    localparam logic [31:0] BUS_CFG_ADDR          = 32'hffffc004; // bus width / mode-bit enables
    localparam logic [31:0] STATUS_ADDR           = 32'hffffc008; // card cycle and mode command status
    localparam logic [15:0] STROBE_TIMING_RESET   = 16'h0000;
    localparam logic [15:0] STROBE_TIMING_WMASK   = 16'hcfff;     // bits 13:12 reserved
    localparam logic [2:0]  BUS_CFG_RESET         = 3'h0;
    // field positions inside card_strobe_timing
    localparam int A5_ASSERT_HI = 11;
    localparam int A5_ASSERT_M  = 7;
    localparam int A5_ASSERT_L  = 6;
    localparam int A6_ASSERT_HI = 10;
    localparam int A6_ASSERT_M  = 5;
    localparam int A6_ASSERT_L  = 4;
    localparam int A5_HOLD_HI   = 9;
    localparam int A5_HOLD_M    = 3;
    localparam int A5_HOLD_L    = 2;
    localparam int A6_HOLD_HI   = 8;
    localparam int A6_HOLD_M    = 1;
    localparam int A6_HOLD_L    = 0;
    // bus_cfg bits
    localparam int CFG_BUS32    = 0;  // 1: 32-bit bus, 0: 16-bit
    localparam int CFG_BIT10_EN = 1;  // mode offset bit 10 writable
    localparam int CFG_BIT11_EN = 2;  // mode offset bit 11 writable
    // memory command phase length in cycles
    localparam int MRS_CYCLES   = 2;
    localparam logic [1:0] MRS_LAST = 2'(MRS_CYCLES - 1);
    // card cycle: each phase counts half cycles, code n gives 2n+1 half cycles
    localparam logic [3:0] HALF_BASE = 4'h1;
    localparam logic [3:0] STROBE_HALVES = 4'h2; // fixed strobe width stands in for wait states
    typedef enum logic [1:0] {
        CARD_IDLE   = 2'b00,
        CARD_SETUP  = 2'b01,
        CARD_STROBE = 2'b11,
        CARD_HOLD   = 2'b10
    } card_state_t;
endpackage : strobe_mode_pkg
